// file: core/podc_pkg.sv
// Constants for the port output drive configuration block
// What this block does
// - Address register value 03H steers control register accesses to open-drain bits.
// - An open-drain bit at 1 makes its pin an open-drain output.
// - Open-drain selection acts at the pad, alternate functions included.
// - Open-drain bit at 1 disables the drain driver for a high level, whatever the alternate enable.
// - Open-drain bit at 0 leaves drain enabled unless alternate function overrides.
// - Address register value 04H steers control register accesses to high-drive bits.
// - High-drive bit 1 selects high current, 0 standard drive strength.
// - High-drive selection acts at the pad, alternate functions included.
package podc_pkg;
    localparam logic [7:0] SUBREG_OPEN_DRAIN = 8'h03;
    localparam logic [7:0] SUBREG_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] OPEN_DRAIN_RESET = 8'h00;
    localparam logic [7:0] HIGH_DRIVE_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h00;
endpackage

// file: core/podc_port_drive.sv
// Port output drive configuration: open-drain and high-drive subregisters
`timescale 1ns/1ns
`default_nettype none
module podc_port_drive #(
    parameter int WIDTH = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_addr_wr,
    input wire logic [7:0] i_addr_wdata,
    input wire logic i_ctrl_wr,
    input wire logic [7:0] i_ctrl_wdata,
    input wire logic [WIDTH-1:0] i_out_data,
    input wire logic [WIDTH-1:0] i_out_en,
    input wire logic [WIDTH-1:0] i_alt_en,
    input wire logic [WIDTH-1:0] i_alt_data,
    input wire logic [WIDTH-1:0] i_alt_oe,
    output logic [7:0] o_addr_rdata,
    output logic [7:0] o_ctrl_rdata,
    output logic [WIDTH-1:0] o_pad_out,
    output logic [WIDTH-1:0] o_pad_oe,
    output logic [WIDTH-1:0] o_pad_high_drive,
    output logic [WIDTH-1:0] o_open_drain_select_bits
);
    typedef struct packed {
        logic [7:0] addr;
        logic [WIDTH-1:0] open_drain;
        logic [WIDTH-1:0] high_drive;
        logic [7:0] ctrl_rdata;
        logic [WIDTH-1:0] pad_out;
        logic [WIDTH-1:0] pad_oe;
        logic [WIDTH-1:0] pad_hd;
    } podc_state_t;

    podc_state_t st;
    podc_state_t next_st;

    // Subregisters may be narrower than the byte-wide control register
    function automatic logic [7:0] podc_widen(input logic [WIDTH-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        r[WIDTH-1:0] = v;
        return r;
    endfunction

    always_comb begin
        logic [WIDTH-1:0] drv;
        logic [WIDTH-1:0] en;
        logic [WIDTH-1:0] od;
        drv = '0;
        en = '0;
        od = '0;
        next_st = st;
        if (i_addr_wr) begin
            next_st.addr = i_addr_wdata;
        end
        if (i_ctrl_wr) begin
            // Only the selected subregister changes; an index written in
            // the same cycle applies from the next write on
            if (st.addr == podc_pkg::SUBREG_OPEN_DRAIN) begin
                next_st.open_drain = i_ctrl_wdata[WIDTH-1:0];
            end else if (st.addr == podc_pkg::SUBREG_HIGH_DRIVE) begin
                next_st.high_drive = i_ctrl_wdata[WIDTH-1:0];
            end
        end
        // Read data follows the selection of the coming cycle
        case (next_st.addr)
            podc_pkg::SUBREG_OPEN_DRAIN:
                next_st.ctrl_rdata = podc_widen(next_st.open_drain);
            podc_pkg::SUBREG_HIGH_DRIVE:
                next_st.ctrl_rdata = podc_widen(next_st.high_drive);
            default:
                next_st.ctrl_rdata = 8'h00;
        endcase
        // Alternate function, when enabled, takes data and enable
        drv = (i_alt_en & i_alt_data) | (~i_alt_en & i_out_data);
        en = (i_alt_en & i_alt_oe) | (~i_alt_en & i_out_en);
        // Open drain: never drive high, pull low only
        od = next_st.open_drain;
        next_st.pad_out = drv & ~od;
        next_st.pad_oe = en & ~(od & drv);
        next_st.pad_hd = next_st.high_drive;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            st.addr <= podc_pkg::ADDR_RESET;
            st.open_drain <= podc_pkg::OPEN_DRAIN_RESET[WIDTH-1:0];
            st.high_drive <= podc_pkg::HIGH_DRIVE_RESET[WIDTH-1:0];
            st.ctrl_rdata <= 8'h00;
            st.pad_out <= '0;
            st.pad_oe <= '0;
            st.pad_hd <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_addr_rdata = st.addr;
    assign o_ctrl_rdata = st.ctrl_rdata;
    assign o_pad_out = st.pad_out;
    assign o_pad_oe = st.pad_oe;
    assign o_pad_high_drive = st.pad_hd;
    assign o_open_drain_select_bits = st.open_drain;

    // Subregister access through the address and control registers
    a_addr_write: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_addr_wr
        |=> st.addr == $past(i_addr_wdata))
        else $error("address register write lost");

    a_od_write: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_ctrl_wr && st.addr == podc_pkg::SUBREG_OPEN_DRAIN
        |=> st.open_drain == $past(i_ctrl_wdata[WIDTH-1:0]))
        else $error("open-drain write lost");

    a_hd_write: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_ctrl_wr && st.addr == podc_pkg::SUBREG_HIGH_DRIVE
        |=> st.high_drive == $past(i_ctrl_wdata[WIDTH-1:0]))
        else $error("high-drive write lost");

    a_other_kept: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        st.addr != podc_pkg::SUBREG_OPEN_DRAIN
        |=> $stable(st.open_drain))
        else $error("open-drain changed while unselected");

    a_hd_kept: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        st.addr != podc_pkg::SUBREG_HIGH_DRIVE
        |=> $stable(st.high_drive))
        else $error("high-drive changed while unselected");

    a_readback: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        st.addr == podc_pkg::SUBREG_OPEN_DRAIN
        |-> st.ctrl_rdata == podc_widen(st.open_drain))
        else $error("control read mismatch");

    a_hd_readback: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        st.addr == podc_pkg::SUBREG_HIGH_DRIVE
        |-> st.ctrl_rdata == podc_widen(st.high_drive))
        else $error("high-drive read mismatch");

    a_other_reads_zero: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        st.addr != podc_pkg::SUBREG_OPEN_DRAIN
        && st.addr != podc_pkg::SUBREG_HIGH_DRIVE
        |-> st.ctrl_rdata == 8'h00)
        else $error("unselected index reads nonzero");

    // Pad checks other than a_od_no_high and a_hd_pad look one cycle back; the first cycle after reset
    // release is skipped because its state still comes from reset.
    a_od_no_high: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (st.pad_oe & st.open_drain & st.pad_out) == '0)
        else $error("open-drain pin driven high");

    a_od_sinks: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        $past(i_rst_b) |-> (($past(~i_alt_en & i_out_en & ~i_out_data)
        & st.open_drain & ~st.pad_oe) == '0))
        else $error("open-drain pin failed to pull low");

    a_od_alt: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        $past(i_rst_b) |-> (($past(i_alt_en & i_alt_data)
        & st.open_drain & st.pad_oe) == '0))
        else $error("alternate function drove high on open-drain pin");

    a_od_alt_low: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        $past(i_rst_b) |-> (($past(i_alt_en & i_alt_oe & ~i_alt_data)
        & st.open_drain & ~st.pad_oe) == '0))
        else $error("alternate low not driven on open-drain pin");

    a_drain_on: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        $past(i_rst_b) |-> (($past(~i_alt_en & i_out_en)
        & ~st.open_drain & ~st.pad_oe) == '0))
        else $error("drain disabled on push-pull pin");

    a_alt_off: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        $past(i_rst_b) |-> (($past(i_alt_en & ~i_alt_oe)
        & st.pad_oe) == '0))
        else $error("pad driven while alternate function is off");

    a_hd_pad: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_ctrl_wr && st.addr == podc_pkg::SUBREG_HIGH_DRIVE
        |=> st.pad_hd == $past(i_ctrl_wdata[WIDTH-1:0]))
        else $error("high drive not at pad");

    // Values right after reset release
    a_reset_std_drive: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        !$past(i_rst_b) |-> st.high_drive == '0 && st.pad_hd == '0)
        else $error("high drive set after reset");

    a_reset_push_pull: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        !$past(i_rst_b) |-> st.open_drain == '0 && st.pad_out == '0)
        else $error("open drain set after reset");

    // Main scenarios
    c_od_sel: cover property (@(posedge i_clock)
        i_ctrl_wr && st.addr == podc_pkg::SUBREG_OPEN_DRAIN);
    c_hd_sel: cover property (@(posedge i_clock)
        i_ctrl_wr && st.addr == podc_pkg::SUBREG_HIGH_DRIVE);
    c_alt_od: cover property (@(posedge i_clock) |(i_alt_en & st.open_drain));
    c_alt_off: cover property (@(posedge i_clock) |(i_alt_en & ~i_alt_oe));
    c_od_release: cover property (@(posedge i_clock)
        |(st.open_drain & ~st.pad_oe));
endmodule
`default_nettype wire

// file: testbench/podc_pad_model.sv
// Pad model: external pull-up on every port pin
`timescale 1ns/1ns
`default_nettype none
module podc_pad_model (
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    output logic [7:0] o_level
);
    // Released pins float up through the pull-up
    assign o_level = (i_out & i_oe) | ~i_oe;
endmodule
`default_nettype wire

// file: testbench/podc_port_drive_tb_top.sv
// Testbench for the port output drive configuration block
`timescale 1ns/1ns
`default_nettype none
module podc_port_drive_tb_top;
    logic i_clock = 1'h0, i_rst_b = 1'h0, aw = 1'h0, cw = 1'h0;
    logic [7:0] ad = 8'h00, cd = 8'h00, alt = 8'h00, dat = 8'h00;
    logic [7:0] aoe = 8'hFF;
    logic [7:0] ar, cr, po, oe, hd, ods, lvl;
    int err_total = 0, checked = 0;
    logic [31:0] rows [4] = '{32'h00FFFFFF, 32'hFF00A55A, 32'h0F3CC3FC,
        32'hA55A0FFA};
    always #4 i_clock = ~i_clock;
    podc_port_drive podc_port_drive_inst (.i_clock(i_clock),
        .i_rst_b(i_rst_b), .i_addr_wr(aw), .i_addr_wdata(ad),
        .i_ctrl_wr(cw), .i_ctrl_wdata(cd), .i_out_data(dat ^ alt),
        .i_out_en(~alt), .i_alt_en(alt), .i_alt_data(dat),
        .i_alt_oe(aoe), .o_addr_rdata(ar), .o_ctrl_rdata(cr),
        .o_pad_out(po), .o_pad_oe(oe), .o_pad_high_drive(hd),
        .o_open_drain_select_bits(ods));
    podc_pad_model podc_pad_model_inst (.i_out(po), .i_oe(oe),
        .o_level(lvl));
    task automatic chk(input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Index write then optional control write, back to back
    task automatic wr(input logic [7:0] idx, val, input logic go);
        @(posedge i_clock);
        aw <= 1'h1;
        ad <= idx;
        @(posedge i_clock);
        aw <= 1'h0;
        cw <= go;
        cd <= val;
        @(posedge i_clock);
        cw <= 1'h0;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clock);
        i_rst_b <= 1'h1;
        wr(8'h03, 8'h00, 1'h0);
        chk(cr, 8'h00);
        wr(8'h04, 8'h00, 1'h0);
        chk(cr, 8'h00);
        foreach (rows[i]) begin
            @(posedge i_clock);
            alt <= i[0] ? 8'hFF : 8'h00;
            dat <= rows[i][15:8];
            wr(8'h03, rows[i][31:24], 1'h1);
            wr(8'h04, rows[i][23:16], 1'h1);
            chk(oe, rows[i][7:0]);
            chk(hd, rows[i][23:16]);
            chk(lvl, rows[i][15:8]);
            chk(ods, rows[i][31:24]);
        end
        // Alternate function turns its driver off on every pin
        @(posedge i_clock);
        aoe <= 8'h00;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        chk(oe, 8'h00);
        // Unknown index must leave both subregisters alone
        wr(8'h05, 8'h55, 1'h1);
        chk(cr, 8'h00);
        wr(8'h03, 8'h00, 1'h0);
        chk(cr, 8'hA5);
        chk(ar, 8'h03);
        wr(8'h04, 8'h00, 1'h0);
        chk(cr, 8'h5A);
        @(posedge i_clock);
        i_rst_b <= 1'h0;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        chk(hd, 8'h00);
        chk(ods, 8'h00);
        chk(po, 8'h00);
        chk(oe, 8'h00);
        chk(cr, 8'h00);
        chk(ar, 8'h00);
        tally_and_finish();
    end
    initial begin
        #20000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
